// >>> common/syncc_defines.svh
// Summary of operation
// - stage one compares reference against y side
// - stage two pair selectable, default reference/z
// - six breaker objects, defaults one and two
// - object select input picks alternate object
// - off mode checks voltages only; default phase-zero
// - slip mode checks limits and closing time
// - phase-zero mode closes at zero angle
// - first letter reference (y for pair y/z), second letter comparison
// - dead below dead limit, live above live limit
// - closing time 0.04 to 0.6 s, default 0.1
// - bypass input passes close without checking
// - bypass status reads one, writable manual bypass
// - four setting groups, input selects group
// - live values and status presented
// - record angle at command and at close
// - elapsed wait as percent of timeout
// - request held until breaker closed
// - ok shows conditions or voltage check met
// - fail when timeout expires before close
// - operator close only starts a request
`ifndef SYNCC_DEFINES_SVH
`define SYNCC_DEFINES_SVH
`define SYNCC_CLK_HZ 40000000
`define SYNCC_TICK_US 1000
`define SYNCC_TICK_CYC ((`SYNCC_CLK_HZ / 1000000) * `SYNCC_TICK_US)
`define SYNCC_CBTIME_MIN_MS 40
`define SYNCC_CBTIME_MAX_MS 600
`define SYNCC_CBTIME_DEF_MS 100
`define SYNCC_PAIR_DEF 2'h1
`define SYNCC_OBJ_PRI_DEF 3'h0
`define SYNCC_OBJ_ALT_DEF 3'h1
`define SYNCC_TIMEOUT_DEF_MS 16'h2710
`define SYNCC_DF_DEF 16'h001E
`define SYNCC_DU_DEF 16'h000A
`define SYNCC_COMMAND_ANGLE_DIFFERENCE_DEF 16'h000A
`define SYNCC_DEAD_DEF 16'h0014
`define SYNCC_LIVE_DEF 16'h0050
`define SYNCC_ZERO_TOL 16'h0001
`define SYNCC_A_CTRL 12'h000
`define SYNCC_A_OBJ 12'h004
`define SYNCC_A_STATUS 12'h008
`define SYNCC_A_LIVE 12'h00C
`define SYNCC_A_RATIO 12'h010
`define SYNCC_A_REQCNT 12'h014
`define SYNCC_A_OKCNT 12'h018
`define SYNCC_A_FAILCNT 12'h01C
`define SYNCC_A_ANG 12'h020
`define SYNCC_A_GRP0 12'h040
`define SYNCC_GRP_STRIDE 12'h020
`define SYNCC_G_MODE 3'h0
`define SYNCC_G_CBT 3'h1
`define SYNCC_G_TMO 3'h2
`define SYNCC_G_DF 3'h3
`define SYNCC_G_DU 3'h4
`define SYNCC_G_COMMAND_ANGLE_DIFFERENCE 3'h5
`define SYNCC_G_DEAD 3'h6
`define SYNCC_G_LIVE 3'h7
`endif

// >>> common/syncc_pkg.sv
package syncc_pkg;
    typedef enum logic [1:0] {SYNCC_M_ASYNC = 2'h0, SYNCC_M_SYNC = 2'h1, SYNCC_M_OFF = 2'h2} syncc_mode_t;
    typedef enum logic [1:0] {SYNCC_P_REF_Y = 2'h0, SYNCC_P_REF_Z = 2'h1, SYNCC_P_Y_Z = 2'h2} syncc_pair_t;
    // voltage code: bit0 DD, bit1 DL, bit2 LD; zero means none
    typedef logic [2:0] syncc_ucode_t;
    typedef enum logic [1:0] {SYNCC_S_IDLE = 2'b00, SYNCC_S_WAIT = 2'b01, SYNCC_S_HAND = 2'b11,
        SYNCC_S_FAIL = 2'b10} syncc_state_t;
    typedef struct packed {
        logic [15:0] volt;
        logic [15:0] freq;
        logic signed [15:0] angle;
    } syncc_meas_t;
    typedef struct packed {
        syncc_mode_t mode;
        syncc_ucode_t ucode;
        logic [15:0] cbtime_ms;
        logic [15:0] timeout_ms;
        logic [15:0] df_lim;
        logic [15:0] du_lim;
        logic [15:0] command_angle_difference_lim;
        logic [15:0] dead_lim;
        logic [15:0] live_lim;
    } syncc_grp_t;
endpackage

// >>> logic/syncc_top.sv
`timescale 1ns/1ps
`include "syncc_defines.svh"
module syncc_top (
    input wire logic sys_clk, // 40 MHz clock
    input wire logic rst_n, // async reset, active low
    input wire logic [11:0] paddr, // apb byte address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire syncc_pkg::syncc_meas_t meas_ref, // reference line voltage
    input wire syncc_pkg::syncc_meas_t meas_y, // comparison voltage y
    input wire syncc_pkg::syncc_meas_t meas_z, // comparison voltage z
    input wire logic close_cmd, // operator close pulse
    input wire logic bypass_input_pin, // bypass digital input
    input wire logic object_select_pin, // object select input
    input wire logic [1:0] group_select_pin, // group select input
    input wire logic breaker_closed, // breaker closed feedback
    output logic [5:0] breaker_command, // close to breaker objects
    output logic sync_request, // request active
    output logic sync_ok, // conditions met
    output logic sync_fail // request timed out
);
    // ****************
    // pin synchronisers
    // ****************
    logic [2:0] byp_sr, osel_sr, gsel_sr, gsel1_sr, cbc_sr;
    logic byp_q, osel_q, cbc_q;
    logic [1:0] gsel_q;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            byp_sr <= 3'h0; osel_sr <= 3'h0; gsel_sr <= 3'h0; gsel1_sr <= 3'h0; cbc_sr <= 3'h0;
            byp_q <= 1'b0; osel_q <= 1'b0; gsel_q <= 2'h0; cbc_q <= 1'b0;
        end
        else
        begin
            byp_sr <= {byp_sr[1:0], bypass_input_pin};
            osel_sr <= {osel_sr[1:0], object_select_pin};
            gsel_sr <= {gsel_sr[1:0], group_select_pin[0]};
            gsel1_sr <= {gsel1_sr[1:0], group_select_pin[1]};
            cbc_sr <= {cbc_sr[1:0], breaker_closed};
            if (byp_sr[2] == byp_sr[1]) byp_q <= byp_sr[2];
            if (osel_sr[2] == osel_sr[1]) osel_q <= osel_sr[2];
            if (gsel_sr[2] == gsel_sr[1]) gsel_q[0] <= gsel_sr[2];
            if (gsel1_sr[2] == gsel1_sr[1]) gsel_q[1] <= gsel1_sr[2];
            if (cbc_sr[2] == cbc_sr[1]) cbc_q <= cbc_sr[2];
        end
    end
    // ****************
    // registers
    // ****************
    syncc_pkg::syncc_pair_t pair_reg;
    logic man_bypass_reg, grp_di_en_reg, show_info_reg;
    logic [1:0] grp_sw_reg;
    logic [2:0] obj_pri_reg, obj_alt_reg;
    syncc_pkg::syncc_grp_t grp_reg [4];
    logic [15:0] req_cnt_reg, ok_cnt_reg, fail_cnt_reg;
    logic signed [15:0] ang_cmd_reg, ang_close_reg;
    logic [7:0] ratio_reg;
    wire wr_en = psel && penable && pwrite;
    wire in_grp = (paddr >= `SYNCC_A_GRP0) && (paddr < `SYNCC_A_GRP0 + 4 * `SYNCC_GRP_STRIDE) && (paddr[1:0] == 2'h0);
    wire [11:0] grp_off = paddr - `SYNCC_A_GRP0;
    wire [1:0] grp_idx = grp_off[6:5];
    wire [2:0] grp_fld = grp_off[4:2];
    // ****************
    // active group and selection
    // ****************
    wire [1:0] act_grp = grp_di_en_reg ? gsel_q : grp_sw_reg;
    syncc_pkg::syncc_grp_t g;
    assign g = grp_reg[act_grp];
    // stage one would tie pair to reference/y; this instance is stage two
    wire sel_y_ref = (pair_reg == syncc_pkg::SYNCC_P_Y_Z);
    syncc_pkg::syncc_meas_t ma, mb;
    assign ma = sel_y_ref ? meas_y : meas_ref;
    assign mb = (pair_reg == syncc_pkg::SYNCC_P_REF_Y) ? meas_y : meas_z;
    wire [15:0] du = (ma.volt > mb.volt) ? ma.volt - mb.volt : mb.volt - ma.volt;
    wire [15:0] df = (ma.freq > mb.freq) ? ma.freq - mb.freq : mb.freq - ma.freq;
    wire signed [15:0] command_angle_difference_s = ma.angle - mb.angle;
    wire [15:0] command_angle_difference = command_angle_difference_s[15] ? 16'(-command_angle_difference_s) : command_angle_difference_s;
    // ****************
    // voltage check
    // ****************
    wire a_dead = ma.volt < g.dead_lim;
    wire a_live = ma.volt > g.live_lim;
    wire b_dead = mb.volt < g.dead_lim;
    wire b_live = mb.volt > g.live_lim;
    wire [2:0] vstate = {a_live && b_dead, a_dead && b_live, a_dead && b_dead};
    wire vcheck_on = g.ucode != 3'h0;
    wire vcheck_ok = |(vstate & g.ucode);
    // ****************
    // synchronism check
    // ****************
    // time to zero angle in ms: command_angle_difference(deg) / (360 * df(0.01 Hz) / 100) * 1000
    wire [31:0] t_rem_ms = (df == 16'h0) ? 32'hFFFF_FFFF : (32'(command_angle_difference) * 32'd100000) / (32'(df) * 32'd360);
    wire lim_ok = (du <= g.du_lim) && (df <= g.df_lim);
    wire async_ok = lim_ok && (command_angle_difference <= g.command_angle_difference_lim) && (t_rem_ms > 32'(g.cbtime_ms));
    wire sync_ok_c = lim_ok && (command_angle_difference <= `SYNCC_ZERO_TOL);
    logic sync_cond;
    always_comb
    begin
        case (g.mode)
            syncc_pkg::SYNCC_M_OFF: sync_cond = 1'b0;
            syncc_pkg::SYNCC_M_ASYNC: sync_cond = async_ok;
            syncc_pkg::SYNCC_M_SYNC: sync_cond = sync_ok_c;
            default: sync_cond = 1'b0;
        endcase
    end
    wire bypassed = byp_q || man_bypass_reg;
    wire ok_c = bypassed || sync_cond || (vcheck_on && vcheck_ok)
        || (g.mode == syncc_pkg::SYNCC_M_OFF && !vcheck_on);
    // ****************
    // timing tick and request machine
    // ****************
    logic [15:0] tick_cnt_reg;
    wire tick = tick_cnt_reg == 16'(`SYNCC_TICK_CYC - 1);
    syncc_pkg::syncc_state_t st_reg, st_next;
    logic [15:0] ms_reg;
    wire timeout = ms_reg >= g.timeout_ms;
    wire [2:0] obj_sel = osel_q ? obj_alt_reg : obj_pri_reg;
    always_comb
    begin
        st_next = st_reg;
        case (st_reg)
            syncc_pkg::SYNCC_S_IDLE: if (close_cmd) st_next = syncc_pkg::SYNCC_S_WAIT;
            syncc_pkg::SYNCC_S_WAIT:
                if (ok_c) st_next = syncc_pkg::SYNCC_S_HAND;
                else if (timeout) st_next = syncc_pkg::SYNCC_S_FAIL;
            syncc_pkg::SYNCC_S_HAND: if (cbc_q) st_next = syncc_pkg::SYNCC_S_IDLE;
            syncc_pkg::SYNCC_S_FAIL: if (close_cmd) st_next = syncc_pkg::SYNCC_S_WAIT;
            default: st_next = syncc_pkg::SYNCC_S_IDLE;
        endcase
    end
    wire enter_wait = close_cmd && (st_reg == syncc_pkg::SYNCC_S_IDLE || st_reg == syncc_pkg::SYNCC_S_FAIL);
    wire issue = st_reg == syncc_pkg::SYNCC_S_WAIT && st_next == syncc_pkg::SYNCC_S_HAND;
    wire closed_ev = st_reg == syncc_pkg::SYNCC_S_HAND && cbc_q;
    wire fail_ev = st_reg == syncc_pkg::SYNCC_S_WAIT && st_next == syncc_pkg::SYNCC_S_FAIL;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= syncc_pkg::SYNCC_S_IDLE;
            tick_cnt_reg <= 16'h0;
            ms_reg <= 16'h0;
        end
        else
        begin
            st_reg <= st_next;
            tick_cnt_reg <= (tick || enter_wait) ? 16'h0 : tick_cnt_reg + 16'h1;
            if (enter_wait) ms_reg <= 16'h0;
            else if (st_reg == syncc_pkg::SYNCC_S_WAIT && tick && !timeout) ms_reg <= ms_reg + 16'h1;
        end
    end
    // ****************
    // outputs, records and counters
    // ****************
    wire [31:0] ratio_c = (g.timeout_ms == 16'h0) ? 32'd100 : (32'(ms_reg) * 32'd100) / 32'(g.timeout_ms);
    wire [5:0] cmd_c = (st_reg == syncc_pkg::SYNCC_S_HAND) ? 6'(6'h1 << obj_sel) : 6'h0;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            breaker_command <= 6'h0; sync_request <= 1'b0; sync_ok <= 1'b0; sync_fail <= 1'b0;
            req_cnt_reg <= 16'h0; ok_cnt_reg <= 16'h0; fail_cnt_reg <= 16'h0;
            ang_cmd_reg <= 16'h0; ang_close_reg <= 16'h0; ratio_reg <= 8'h0;
        end
        else
        begin
            breaker_command <= cmd_c;
            sync_request <= st_next == syncc_pkg::SYNCC_S_WAIT || st_next == syncc_pkg::SYNCC_S_HAND;
            sync_ok <= ok_c;
            sync_fail <= st_next == syncc_pkg::SYNCC_S_FAIL;
            if (enter_wait) req_cnt_reg <= req_cnt_reg + 16'h1;
            if (closed_ev) ok_cnt_reg <= ok_cnt_reg + 16'h1;
            if (fail_ev) fail_cnt_reg <= fail_cnt_reg + 16'h1;
            if (issue) ang_cmd_reg <= command_angle_difference_s;
            if (closed_ev) ang_close_reg <= command_angle_difference_s;
            if (st_reg == syncc_pkg::SYNCC_S_WAIT || enter_wait) ratio_reg <= enter_wait ? 8'h0 : ratio_c[7:0];
        end
    end
    // ****************
    // apb slave
    // ****************
    assign pready = 1'b1;
    wire known = (paddr <= `SYNCC_A_ANG && paddr[1:0] == 2'h0) || in_grp;
    assign pslverr = psel && penable && !known;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pair_reg <= syncc_pkg::syncc_pair_t'(`SYNCC_PAIR_DEF);
            man_bypass_reg <= 1'b0; grp_di_en_reg <= 1'b0; grp_sw_reg <= 2'h0; show_info_reg <= 1'b1;
            obj_pri_reg <= `SYNCC_OBJ_PRI_DEF; obj_alt_reg <= `SYNCC_OBJ_ALT_DEF;
            for (int i = 0; i < 4; i++)
                grp_reg[i] <= '{mode: syncc_pkg::SYNCC_M_SYNC, ucode: 3'h0, cbtime_ms: 16'(`SYNCC_CBTIME_DEF_MS),
                    timeout_ms: `SYNCC_TIMEOUT_DEF_MS, df_lim: `SYNCC_DF_DEF, du_lim: `SYNCC_DU_DEF,
                    command_angle_difference_lim: `SYNCC_COMMAND_ANGLE_DIFFERENCE_DEF, dead_lim: `SYNCC_DEAD_DEF, live_lim: `SYNCC_LIVE_DEF};
        end
        else if (wr_en)
        begin
            if (paddr == `SYNCC_A_CTRL)
            begin
                if (pwdata[1:0] != 2'h3) pair_reg <= syncc_pkg::syncc_pair_t'(pwdata[1:0]);
                man_bypass_reg <= pwdata[2];
                grp_di_en_reg <= pwdata[3];
                grp_sw_reg <= pwdata[5:4];
                show_info_reg <= pwdata[6];
            end
            if (paddr == `SYNCC_A_OBJ)
            begin
                if (pwdata[2:0] < 3'h6) obj_pri_reg <= pwdata[2:0];
                if (pwdata[6:4] < 3'h6) obj_alt_reg <= pwdata[6:4];
            end
            if (in_grp)
                case (grp_fld)
                    `SYNCC_G_MODE:
                    begin
                        if (pwdata[1:0] != 2'h3) grp_reg[grp_idx].mode <= syncc_pkg::syncc_mode_t'(pwdata[1:0]);
                        grp_reg[grp_idx].ucode <= pwdata[6:4];
                    end
                    `SYNCC_G_CBT:
                        if (pwdata[15:0] >= 16'(`SYNCC_CBTIME_MIN_MS) && pwdata[15:0] <= 16'(`SYNCC_CBTIME_MAX_MS))
                            grp_reg[grp_idx].cbtime_ms <= pwdata[15:0];
                    `SYNCC_G_TMO: grp_reg[grp_idx].timeout_ms <= pwdata[15:0];
                    `SYNCC_G_DF: grp_reg[grp_idx].df_lim <= pwdata[15:0];
                    `SYNCC_G_DU: grp_reg[grp_idx].du_lim <= pwdata[15:0];
                    `SYNCC_G_COMMAND_ANGLE_DIFFERENCE: grp_reg[grp_idx].command_angle_difference_lim <= pwdata[15:0];
                    `SYNCC_G_DEAD: grp_reg[grp_idx].dead_lim <= pwdata[15:0];
                    `SYNCC_G_LIVE: grp_reg[grp_idx].live_lim <= pwdata[15:0];
                    default: ;
                endcase
        end
    end
    syncc_pkg::syncc_grp_t rg;
    assign rg = grp_reg[grp_idx];
    logic [31:0] grp_rd;
    always_comb
    begin
        case (grp_fld)
            `SYNCC_G_MODE: grp_rd = {25'h0, rg.ucode, 2'h0, rg.mode};
            `SYNCC_G_CBT: grp_rd = {16'h0, rg.cbtime_ms};
            `SYNCC_G_TMO: grp_rd = {16'h0, rg.timeout_ms};
            `SYNCC_G_DF: grp_rd = {16'h0, rg.df_lim};
            `SYNCC_G_DU: grp_rd = {16'h0, rg.du_lim};
            `SYNCC_G_COMMAND_ANGLE_DIFFERENCE: grp_rd = {16'h0, rg.command_angle_difference_lim};
            `SYNCC_G_DEAD: grp_rd = {16'h0, rg.dead_lim};
            default: grp_rd = {16'h0, rg.live_lim};
        endcase
    end
    logic [31:0] rd_c;
    always_comb
    begin
        rd_c = 32'h0;
        if (in_grp) rd_c = grp_rd;
        else
            case (paddr)
                `SYNCC_A_CTRL: rd_c = {25'h0, show_info_reg, grp_sw_reg, grp_di_en_reg, man_bypass_reg, pair_reg};
                `SYNCC_A_OBJ: rd_c = {25'h0, obj_alt_reg, 1'b0, obj_pri_reg};
                `SYNCC_A_STATUS: rd_c = {16'h0, 2'h0, act_grp, 1'b0, vstate, st_reg, sync_fail, sync_ok,
                    sync_request, bypassed, 2'h0};
                `SYNCC_A_LIVE: rd_c = {df, du};
                `SYNCC_A_RATIO: rd_c = {command_angle_difference, 8'h0, ratio_reg};
                `SYNCC_A_REQCNT: rd_c = {16'h0, req_cnt_reg};
                `SYNCC_A_OKCNT: rd_c = {16'h0, ok_cnt_reg};
                `SYNCC_A_FAILCNT: rd_c = {16'h0, fail_cnt_reg};
                `SYNCC_A_ANG: rd_c = {ang_close_reg, ang_cmd_reg};
                default: rd_c = 32'h0;
            endcase
    end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n) prdata <= 32'h0;
        else if (psel && !penable && !pwrite) prdata <= rd_c;
    end
    // ****************
    // assertions
    // ****************
    req_until_close_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_reg == syncc_pkg::SYNCC_S_HAND && !cbc_q) |=> sync_request) else $error("request dropped early");
    fail_on_tmo_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fail_ev |=> sync_fail) else $error("fail not raised");
    cmd_onehot_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $onehot0(breaker_command)) else $error("many objects driven");
    alt_obj_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_reg == syncc_pkg::SYNCC_S_HAND && osel_q && $stable(osel_q)) |=> breaker_command[obj_alt_reg])
        else $error("alternate object unused");
    bypass_ok_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        bypassed |=> sync_ok) else $error("bypass not passing");
    req_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        enter_wait |=> req_cnt_reg == $past(req_cnt_reg) + 16'h1) else $error("request count");
    ang_rec_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        issue |=> ang_cmd_reg == $past(command_angle_difference_s)) else $error("angle not recorded");
    no_cmd_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_reg == syncc_pkg::SYNCC_S_IDLE) |=> breaker_command == 6'h0) else $error("close without request");
    close_cov: cover property (@(posedge sys_clk) disable iff (!rst_n) closed_ev);
    fail_cov: cover property (@(posedge sys_clk) disable iff (!rst_n) fail_ev);
    byp_cov: cover property (@(posedge sys_clk) disable iff (!rst_n) bypassed && issue);
endmodule

// >>> dv/syncc_breaker_model.sv
`timescale 1ns/1ps
// ****************************************
// breaker object: closes after a delay
// ****************************************
module syncc_breaker_model (
    input wire logic sys_clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic [5:0] breaker_command, // close from the stage
    input wire logic open_req, // bench opens the breaker
    input wire logic [7:0] close_dly, // closing delay in cycles
    output logic breaker_closed // breaker position
);
    logic [7:0] dly_reg;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dly_reg <= 8'h00;
            breaker_closed <= 1'b0;
        end
        else if (open_req)
        begin
            dly_reg <= 8'h00;
            breaker_closed <= 1'b0;
        end
        else if (breaker_command == 6'h00)
        begin
            // a command that drops early aborts the close
            dly_reg <= 8'h00;
        end
        else if (dly_reg >= close_dly)
        begin
            breaker_closed <= 1'b1;
        end
        else
        begin
            dly_reg <= dly_reg + 8'h01;
        end
    end
endmodule

// >>> dv/test_synchrocheck_close_supervisor.sv
`timescale 1ns/1ps
module test_synchrocheck_close_supervisor;
    typedef struct packed {logic [2:0] uc; logic [15:0] rv; logic [15:0] zv; logic ok; logic [2:0] vs;} syncc_row_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    syncc_pkg::syncc_meas_t meas_ref = '0;
    syncc_pkg::syncc_meas_t meas_y = '0;
    syncc_pkg::syncc_meas_t meas_z = '0;
    logic close_cmd = 1'b0;
    logic bypass_input_pin = 1'b0;
    logic object_select_pin = 1'b0;
    logic [1:0] group_select_pin = 2'h0;
    logic breaker_closed;
    logic [5:0] breaker_command;
    logic sync_request;
    logic sync_ok;
    logic sync_fail;
    logic open_req = 1'b0;
    logic [7:0] close_dly = 8'h1E;
    logic [31:0] rd;
    logic er;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    syncc_row_t rows [12] = '{
        '{3'h0, 16'h0032, 16'h0032, 1'b1, 3'h0}, '{3'h1, 16'h000A, 16'h000A, 1'b1, 3'h1},
        '{3'h1, 16'h000A, 16'h005A, 1'b0, 3'h2}, '{3'h2, 16'h000A, 16'h005A, 1'b1, 3'h2},
        '{3'h4, 16'h005A, 16'h000A, 1'b1, 3'h4}, '{3'h4, 16'h000A, 16'h005A, 1'b0, 3'h2},
        '{3'h3, 16'h000A, 16'h000A, 1'b1, 3'h1}, '{3'h5, 16'h005A, 16'h000A, 1'b1, 3'h4},
        '{3'h6, 16'h000A, 16'h000A, 1'b0, 3'h1}, '{3'h7, 16'h005A, 16'h000A, 1'b1, 3'h4},
        '{3'h1, 16'h0014, 16'h000A, 1'b0, 3'h0}, '{3'h2, 16'h000A, 16'h0050, 1'b0, 3'h0}};
    logic [43:0] defs [10] = '{{12'h000, 32'h0000_0041}, {12'h004, 32'h0000_0010}, {12'h040, 32'h0000_0001},
        {12'h044, 32'h0000_0064}, {12'h048, 32'h0000_2710}, {12'h04C, 32'h0000_001E}, {12'h050, 32'h0000_000A},
        {12'h058, 32'h0000_0014}, {12'h05C, 32'h0000_0050}, {12'h0A0, 32'h0000_0001}};
    logic [31:0] cbt [5] = '{32'h0000_02BC, 32'h0000_0064, 32'h0000_0028, 32'h0000_0027, 32'h0000_0258};
    logic [31:0] cbt_exp [5] = '{32'h0000_0064, 32'h0000_0064, 32'h0000_0028, 32'h0000_0028, 32'h0000_0258};
    logic [17:0] objs [4] = '{{8'h10, 1'b0, 3'h0, 6'h01}, {8'h10, 1'b1, 3'h0, 6'h02},
        {8'h25, 1'b0, 3'h0, 6'h20}, {8'h25, 1'b1, 3'h0, 6'h04}};
    syncc_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas_ref(meas_ref), .meas_y(meas_y), .meas_z(meas_z), .close_cmd(close_cmd),
        .bypass_input_pin(bypass_input_pin), .object_select_pin(object_select_pin),
        .group_select_pin(group_select_pin), .breaker_closed(breaker_closed),
        .breaker_command(breaker_command), .sync_request(sync_request), .sync_ok(sync_ok), .sync_fail(sync_fail));
    syncc_breaker_model i_brk (.sys_clk(sys_clk), .rst_n(rst_n), .breaker_command(breaker_command),
        .open_req(open_req), .close_dly(close_dly), .breaker_closed(breaker_closed));
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: run did not finish", $time);
            close_out();
        end
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic set_meas(input logic [15:0] rv, input logic [15:0] yv, input logic [15:0] zv, input logic [15:0] ra);
        meas_ref <= {rv, 16'h1388, ra};
        meas_y <= {yv, 16'h1388, 16'h0000};
        meas_z <= {zv, 16'h1388, 16'h0000};
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic wait_on(input int lim);
        n = 0;
        @(posedge sys_clk);
        while (n < lim && ((sync_request !== 1'b1 && lim == 4) || (breaker_command === 6'h00 && lim == 20) ||
            (sync_request !== 1'b0 && lim == 300) || (sync_fail !== 1'b1 && lim == 45000)))
        begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    task automatic handover(input logic [5:0] exp_cmd);
        close_cmd <= 1'b1;
        @(posedge sys_clk);
        close_cmd <= 1'b0;
        wait_on(4);
        chk(sync_request, 1'b1, "request after close");
        chk(sync_fail, 1'b0, "fail cleared by new close");
        wait_on(20);
        chk(breaker_command, exp_cmd, "object selected");
        chk(sync_request, 1'b1, "request held while closing");
        wait_on(300);
        @(posedge sys_clk);
        chk({sync_request, breaker_command}, 7'h00, "released after breaker closed");
        open_req <= 1'b1;
        @(posedge sys_clk);
        open_req <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        foreach (rows[i])
        begin
            apb(1'b1, 12'h040, {25'h0, rows[i].uc, 4'h2});
            set_meas(rows[i].rv, 16'h0032, rows[i].zv, 16'h0000);
            chk(sync_ok, rows[i].ok, "voltage check ok");
            apb(1'b0, 12'h008, 32'h0000_0000);
            chk(rd[10:8], rows[i].vs, "voltage state");
        end
        $display("test voltage check rows done");
        apb(1'b1, 12'h000, 32'h0000_0040);
        set_meas(16'h000A, 16'h005A, 16'h000A, 16'h0000);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd[10:8], 3'h2, "pair ref/y");
        apb(1'b1, 12'h000, 32'h0000_0042);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd[10:8], 3'h4, "pair y/z");
        $display("test pair select done");
        rst_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk({breaker_command, sync_request, sync_ok, sync_fail}, 9'h000, "outputs in reset");
        rst_n <= 1'b1;
        @(posedge sys_clk);
        foreach (defs[i])
        begin
            apb(1'b0, defs[i][43:32], 32'h0000_0000);
            chk(rd, defs[i][31:0], "reset value");
        end
        apb(1'b0, 12'h100, 32'h0000_0000);
        chk({er, rd}, {1'b1, 32'h0000_0000}, "unmapped read");
        $display("test reset defaults done");
        foreach (cbt[i])
        begin
            apb(1'b1, 12'h044, cbt[i]);
            apb(1'b0, 12'h044, 32'h0000_0000);
            chk(rd, cbt_exp[i], "closing time range");
        end
        apb(1'b1, 12'h000, 32'h0000_0051);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd[13:12], 2'h1, "software group");
        group_select_pin <= 2'h2;
        apb(1'b1, 12'h000, 32'h0000_0049);
        repeat (6) @(posedge sys_clk);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd[13:12], 2'h2, "group from pin");
        apb(1'b1, 12'h000, 32'h0000_0041);
        $display("test settings done");
        set_meas(16'h0064, 16'h0000, 16'h0064, 16'h0000);
        foreach (objs[i])
        begin
            apb(1'b1, 12'h004, {24'h0, objs[i][17:10]});
            object_select_pin <= objs[i][9];
            close_dly <= (i == 0) ? 8'h00 : 8'h1E;
            repeat (6) @(posedge sys_clk);
            handover(objs[i][5:0]);
        end
        apb(1'b0, 12'h014, 32'h0000_0000);
        chk(rd, 32'h0000_0004, "request count");
        apb(1'b0, 12'h018, 32'h0000_0000);
        chk(rd, 32'h0000_0004, "success count");
        $display("test handover done");
        apb(1'b1, 12'h048, 32'h0000_0001);
        set_meas(16'h0064, 16'h0000, 16'h0064, 16'h002D);
        close_cmd <= 1'b1;
        @(posedge sys_clk);
        close_cmd <= 1'b0;
        wait_on(45000);
        chk({sync_fail, breaker_command}, 7'h40, "fail at timeout, no close");
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(rd, 32'h002D_0064, "wait ratio at timeout");
        apb(1'b0, 12'h01C, 32'h0000_0000);
        chk(rd, 32'h0000_0001, "fail count");
        $display("test timeout done");
        apb(1'b1, 12'h040, 32'h0000_0000);
        meas_ref.angle <= 16'h0005;
        meas_z.freq <= 16'h1387;
        repeat (4) @(posedge sys_clk);
        chk(sync_ok, 1'b1, "slip slow enough");
        meas_z.freq <= 16'h1374;
        repeat (4) @(posedge sys_clk);
        chk(sync_ok, 1'b0, "slip too fast");
        apb(1'b1, 12'h000, 32'h0000_0045);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd[4:2], 3'h5, "manual bypass gives ok");
        apb(1'b1, 12'h000, 32'h0000_0041);
        bypass_input_pin <= 1'b1;
        repeat (6) @(posedge sys_clk);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd[2], 1'b1, "bypass status");
        handover(6'h04);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk(rd, 32'h0005_0005, "recorded angles");
        $display("test bypass done");
        close_out();
    end
endmodule
